// *** rtl/lrc_defines.vh ***
// Constants for the ladder reference control block
// Functional notes
// - Ladder is powered while the power-on bit, bit 7, is one.
// - Routing bit 6 puts the ladder level onto shared port pin two.
// - A set routing bit overrides the pin two direction bit.
// - Range bit 5: one is low range span/24, zero is high range span/32.
// - Supply bit 4: one uses external reference pins, zero uses supply rails.
// - Four-bit level code in bits 3..0 gives sixteen levels per range.
// - High range tap equals span/4 plus code times span/32.
// - Reset clears power, routing, range and level code bits.
// - Wake from sleep leaves every control bit unchanged.
// - Reference works from its own settings, whatever the comparator mode.
// - Level reaches both comparators' plus inputs only in comparator mode 110.
`ifndef LRC_DEFINES_VH
`define LRC_DEFINES_VH

// Register byte addresses
`define LRC_ADDR_CTRL 8'h00
`define LRC_ADDR_STAT 8'h04

// Control register layout and reset value
`define LRC_CTRL_RST 8'h00
`define LRC_BIT_POWER 7
`define LRC_BIT_ROUTE 6
`define LRC_BIT_RANGE 5
`define LRC_BIT_SUPPLY 4
`define LRC_CODE_MSB 3
`define LRC_CODE_LSB 0

// Status register layout
`define LRC_STAT_LEVEL_MSB 6
`define LRC_STAT_CMP_BIT 8
`define LRC_STAT_PIN_BIT 9

// Level expressed in 96ths of the span (common multiple of 4, 24 and 32)
`define LRC_LEVEL_DENOM 7'h60
`define LRC_HIGH_BASE 7'h18
`define LRC_HIGH_STEP 7'h03
`define LRC_LOW_STEP 7'h04

// Comparator mode that takes the ladder level
`define LRC_MODE_REF 3'h6

// Bus responses
`define LRC_RESP_OKAY 2'h0
`define LRC_RESP_SLVERR 2'h2

`endif

// *** rtl/lrc_sync2.v ***
// Two-flop synchroniser for pad inputs
`timescale 1ns/1ps
module lrc_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    ////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule // lrc_sync2

// *** rtl/lrc_tap_decode.v ***
// Decoder from control byte to registered ladder selects
`timescale 1ns/1ps
`include "lrc_defines.vh"
module lrc_tap_decode (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [7:0] ctrl_next_i,
    output reg power_on_o,
    output reg route_o,
    output reg range_o,
    output reg supply_o,
    output reg [3:0] code_o,
    output reg [6:0] level_o
);

    ////////////////////////////////////////////////////////////////
    // Tap level in 96ths of the span
    function [6:0] tap_level;
        input low_range;
        input [3:0] code;
        begin
            if (low_range) begin
                tap_level = `LRC_LOW_STEP * {3'h0, code};
            end else begin
                tap_level = `LRC_HIGH_BASE + `LRC_HIGH_STEP * {3'h0, code};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Registered from the next control value, so selects move on the write edge
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            power_on_o <= 1'b0;
            route_o <= 1'b0;
            range_o <= 1'b0;
            supply_o <= 1'b0;
            code_o <= 4'h0;
            level_o <= `LRC_HIGH_BASE;
        end else begin
            power_on_o <= ctrl_next_i[`LRC_BIT_POWER];
            route_o <= ctrl_next_i[`LRC_BIT_ROUTE];
            range_o <= ctrl_next_i[`LRC_BIT_RANGE];
            supply_o <= ctrl_next_i[`LRC_BIT_SUPPLY];
            code_o <= ctrl_next_i[`LRC_CODE_MSB:`LRC_CODE_LSB];
            level_o <= tap_level(ctrl_next_i[`LRC_BIT_RANGE], ctrl_next_i[`LRC_CODE_MSB:`LRC_CODE_LSB]);
        end
    end

endmodule // lrc_tap_decode

// *** rtl/lrc_top.v ***
// Ladder reference control block with AXI4-Lite register slave
`timescale 1ns/1ps
`include "lrc_defines.vh"
module lrc_top #(
    parameter ADDR_W = 8
) (
    input wire clk_i,
    input wire sys_rst_i,
    // AXI4-Lite write address
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [ADDR_W-1:0] s_axi_awaddr_i,
    input wire [2:0] s_axi_awprot_i,
    // AXI4-Lite write data
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    // AXI4-Lite write response
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    output wire [1:0] s_axi_bresp_o,
    // AXI4-Lite read address
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    input wire [ADDR_W-1:0] s_axi_araddr_i,
    input wire [2:0] s_axi_arprot_i,
    // AXI4-Lite read data
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    // Neighbouring device logic, same clock
    input wire [2:0] comparator_mode_field_i,
    input wire port_a_direction_i,
    // Pad of shared port pin two
    input wire shared_port_pin_two_i,
    output wire shared_port_pin_two_oe_o,
    // Analog ladder controls
    output wire ladder_power_on_o,
    output wire level_to_pin_enable_o,
    output wire ladder_range_select_o,
    output wire ladder_supply_select_o,
    output wire [3:0] ladder_level_code_o,
    output wire [6:0] ladder_tap_level_o,
    output wire comparator_ref_connect_o
);

    ////////////////////////////////////////////////////////////////
    // Register map decode
    localparam SEL_NONE = 2'h0;
    localparam SEL_CTRL = 2'h1;
    localparam SEL_STAT = 2'h2;

    // Only the two aligned words decode, on address bits 7..0 alone; any other low byte is unmapped
    function [1:0] reg_select;
        input [ADDR_W-1:0] addr;
        begin
            if (addr[7:0] == `LRC_ADDR_CTRL) begin
                reg_select = SEL_CTRL;
            end else if (addr[7:0] == `LRC_ADDR_STAT) begin
                reg_select = SEL_STAT;
            end else begin
                reg_select = SEL_NONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Declarations
    reg [7:0] ctrl_reg;
    reg [7:0] ctrl_next;

    // Write address and data holders
    reg aw_full_reg;
    reg aw_full_next;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg w_full_reg;
    reg w_full_next;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    // Bus readies and answer flops
    reg awready_reg;
    reg wready_reg;
    reg bvalid_reg;
    reg bvalid_next;
    reg [1:0] bresp_reg;
    reg arready_reg;
    reg rvalid_reg;
    reg rvalid_next;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;

    // Pin driver, comparator link and status word
    reg pin_oe_reg;
    reg cmp_ref_reg;
    reg [31:0] stat_word;

    // Handshake strobes and register selects
    wire hs_aw;
    wire hs_w;
    wire hs_ar;
    wire do_write;
    wire [1:0] wr_sel;
    wire [1:0] rd_sel;

    // Synchronised pad level and decoded ladder selects
    wire pin_level_sync;
    wire dec_power;
    wire dec_route;
    wire dec_range;
    wire dec_supply;
    wire [3:0] dec_code;
    wire [6:0] dec_level;

    ////////////////////////////////////////////////////////////////
    // Handshakes
    assign hs_aw = s_axi_awvalid_i & awready_reg;
    assign hs_w = s_axi_wvalid_i & wready_reg;
    assign hs_ar = s_axi_arvalid_i & arready_reg;
    // Write waits for both halves and a free response slot
    assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_sel = reg_select(aw_addr_reg);
    // Reads decode the live address, writes the held one
    assign rd_sel = reg_select(s_axi_araddr_i);

    ////////////////////////////////////////////////////////////////
    // Next state of the write channel holders and response
    always @* begin
        aw_full_next = aw_full_reg | hs_aw;
        w_full_next = w_full_reg | hs_w;
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
        end
        // Response stands until the master takes it
        bvalid_next = bvalid_reg;
        if (bvalid_reg & s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            bvalid_next = 1'b1;
        end
        // Read answer stands until the master takes it
        rvalid_next = rvalid_reg;
        if (rvalid_reg & s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
        if (hs_ar) begin
            rvalid_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control register next value; only byte lane 0 carries the byte.
    // Sleep and wake have no path here, so the byte survives wake.
    always @* begin
        ctrl_next = ctrl_reg;
        if (do_write && wr_sel == SEL_CTRL && w_strb_reg[0]) begin
            ctrl_next = w_data_reg[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Write channel registers
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= `LRC_CTRL_RST;
            // Readies stay low in reset and rise at the first edge after it
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= {ADDR_W{1'b0}};
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `LRC_RESP_OKAY;
        end else begin
            // Only a landed write or a device reset moves the control byte
            ctrl_reg <= ctrl_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            // Ready only while the holder is empty, so a held item is never overwritten
            awready_reg <= ~aw_full_next;
            wready_reg <= ~w_full_next;
            if (hs_aw) begin
                aw_addr_reg <= s_axi_awaddr_i;
            end
            if (hs_w) begin
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                // Status is read-only: writes there are dropped but answered OKAY
                bresp_reg <= (wr_sel == SEL_NONE) ? `LRC_RESP_SLVERR : `LRC_RESP_OKAY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status word: tap level, comparator link and pin two pad level
    always @* begin
        stat_word = 32'h00000000;
        stat_word[`LRC_STAT_LEVEL_MSB:0] = dec_level;
        stat_word[`LRC_STAT_CMP_BIT] = cmp_ref_reg;
        // Pad level stays visible even while the ladder is routed to it
        stat_word[`LRC_STAT_PIN_BIT] = pin_level_sync;
    end

    ////////////////////////////////////////////////////////////////
    // Read channel; data taken at the address handshake
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `LRC_RESP_OKAY;
        end else begin
            // Answer flag rises on the handshake edge itself
            rvalid_reg <= rvalid_next;
            // One read in flight at a time
            arready_reg <= ~rvalid_next;
            if (hs_ar) begin
                case (rd_sel)
                    SEL_CTRL: begin
                        rdata_reg <= {24'h000000, ctrl_reg};
                        rresp_reg <= `LRC_RESP_OKAY;
                    end
                    SEL_STAT: begin
                        rdata_reg <= stat_word;
                        rresp_reg <= `LRC_RESP_OKAY;
                    end
                    default: begin
                        rdata_reg <= 32'h00000000;
                        rresp_reg <= `LRC_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin two direction and comparator link.
    // Power never looks at the comparator mode, so the ladder runs alone.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_oe_reg <= 1'b0;
            cmp_ref_reg <= 1'b0;
        end else begin
            // Routing forces the digital driver off whatever the direction bit
            pin_oe_reg <= ~ctrl_next[`LRC_BIT_ROUTE] & ~port_a_direction_i;
            // Ladder reaches the comparators only in the shared reference mode
            cmp_ref_reg <= ctrl_next[`LRC_BIT_POWER] & (comparator_mode_field_i == `LRC_MODE_REF);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pad input crosses in through two flops
    lrc_sync2 #(
        .WIDTH(1)
    ) u_pin_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(shared_port_pin_two_i),
        .sync_o(pin_level_sync)
    );

    ////////////////////////////////////////////////////////////////
    // Ladder select decode
    // Selects registered inside from the next control value
    lrc_tap_decode u_decode (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ctrl_next_i(ctrl_next),
        .power_on_o(dec_power),
        .route_o(dec_route),
        .range_o(dec_range),
        .supply_o(dec_supply),
        .code_o(dec_code),
        .level_o(dec_level)
    );

    ////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign shared_port_pin_two_oe_o = pin_oe_reg;
    assign ladder_power_on_o = dec_power;
    assign level_to_pin_enable_o = dec_route;
    assign ladder_range_select_o = dec_range;
    assign ladder_supply_select_o = dec_supply;
    assign ladder_level_code_o = dec_code;
    assign ladder_tap_level_o = dec_level;
    assign comparator_ref_connect_o = cmp_ref_reg;

endmodule // lrc_top

// *** verif/lrc_properties.sv ***
// Port assertions for the ladder reference control top
`timescale 1ns/1ps
`include "lrc_defines.vh"
module lrc_properties (
    input logic clk_i,
    input logic sys_rst_i,
    input logic s_axi_awvalid_i,
    input logic s_axi_awready_o,
    input logic s_axi_wvalid_i,
    input logic s_axi_wready_o,
    input logic s_axi_bvalid_o,
    input logic s_axi_arvalid_i,
    input logic s_axi_arready_o,
    input logic s_axi_rvalid_o,
    input logic [2:0] comparator_mode_field_i,
    input logic port_a_direction_i,
    input logic shared_port_pin_two_oe_o,
    input logic ladder_power_on_o,
    input logic level_to_pin_enable_o,
    input logic ladder_range_select_o,
    input logic ladder_supply_select_o,
    input logic [3:0] ladder_level_code_o,
    input logic [6:0] ladder_tap_level_o,
    input logic comparator_ref_connect_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Three quiet cycles cover the sampled mode stage
    sequence quiet_inputs;
        ($stable(comparator_mode_field_i) && $stable(ladder_power_on_o)) [*3];
    endsequence
    sequence write_done;
        $rose(s_axi_bvalid_o);
    endsequence
    ////////////////////////////////////////////////////////////
    settings_move_a: assert property (
        !$stable({ladder_power_on_o, level_to_pin_enable_o, ladder_range_select_o, ladder_supply_select_o,
        ladder_level_code_o}) |-> write_done) else $error("settings moved without a write");
    tap_high_a: assert property (
        !ladder_range_select_o |-> ladder_tap_level_o == 7'h18 + 7'h03 * {3'h0, ladder_level_code_o})
        else $error("high range tap wrong");
    tap_low_a: assert property (
        ladder_range_select_o |-> ladder_tap_level_o == {1'b0, ladder_level_code_o, 2'b00})
        else $error("low range tap wrong");
    pin_override_a: assert property (
        level_to_pin_enable_o && $past(level_to_pin_enable_o) |-> !shared_port_pin_two_oe_o)
        else $error("pin driver left on while routed");
    // Direction input has one cycle of lag, so both inputs must be still
    pin_dir_a: assert property (
        !$past(sys_rst_i) && !$past(sys_rst_i, 2) && $stable(level_to_pin_enable_o) && $stable(port_a_direction_i)
        |-> shared_port_pin_two_oe_o == (!level_to_pin_enable_o && !port_a_direction_i))
        else $error("pin driver enable wrong");
    cmp_connect_a: assert property (
        quiet_inputs |-> comparator_ref_connect_o == (ladder_power_on_o && comparator_mode_field_i == `LRC_MODE_REF))
        else $error("comparator connect wrong");
    write_answer_a: assert property (
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_bvalid_o
        |-> ##[1:2] s_axi_bvalid_o) else $error("write response late");
    read_answer_a: assert property (
        s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o) else $error("read data late");
endmodule // lrc_properties

bind lrc_top lrc_properties u_lrc_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .comparator_mode_field_i(comparator_mode_field_i), .port_a_direction_i(port_a_direction_i),
    .shared_port_pin_two_oe_o(shared_port_pin_two_oe_o), .ladder_power_on_o(ladder_power_on_o),
    .level_to_pin_enable_o(level_to_pin_enable_o), .ladder_range_select_o(ladder_range_select_o),
    .ladder_supply_select_o(ladder_supply_select_o), .ladder_level_code_o(ladder_level_code_o),
    .ladder_tap_level_o(ladder_tap_level_o), .comparator_ref_connect_o(comparator_ref_connect_o));

// *** verif/test_lrc_top.sv ***
// Self-checking bench for the ladder reference control top
`timescale 1ns/1ps
`include "lrc_defines.vh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_lrc_top;
    logic clk_i, sys_rst_i, awv, wv, brdy, arv, rrdy, pin, dir;
    logic [7:0] awa, ara, v;
    logic [31:0] wd, rd;
    logic [3:0] ws;
    logic [2:0] mode;
    logic [1:0] resp;
    logic [31:0] seed = 32'hB6E1A846;
    logic [7:0] corner [6] = '{8'h0F, 8'h2F, 8'hFF, 8'hDA, 8'h20, 8'h50};
    wire awr, wrr, bv, arr, rv, oe, pwr, route, rng, sup, conn;
    wire [1:0] br, rr;
    wire [31:0] rdata;
    wire [3:0] code;
    wire [6:0] tap;
    int fails, tests_run;

    lrc_top #(.ADDR_W(8)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(brdy), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rr), .comparator_mode_field_i(mode), .port_a_direction_i(dir),
        .shared_port_pin_two_i(pin), .shared_port_pin_two_oe_o(oe), .ladder_power_on_o(pwr),
        .level_to_pin_enable_o(route), .ladder_range_select_o(rng), .ladder_supply_select_o(sup),
        .ladder_level_code_o(code), .ladder_tap_level_o(tap), .comparator_ref_connect_o(conn));

    ////////////////////////////////////////////////////////////
    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Tap in 96ths of span for a control byte
    function automatic logic [6:0] exp_tap(input logic [7:0] c);
        return c[5] ? {1'b0, c[3:0], 2'b00} : 7'h18 + 7'h03 * {3'h0, c[3:0]};
    endfunction
    task automatic end_of_test();
        $display("Mismatches %0d of %0d comparisons", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One clock with a bound, so no wait can hang the run
    task automatic tick(inout int n);
        @(posedge clk_i);
        n++;
        if (n > 200) begin
            fails++;
            end_of_test();
        end
    endtask
    // Ready raised after a random stall to exercise held responses
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n = 0;
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            tick(n);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrr) wv <= 1'b0;
            if (bv && brdy) break;
            if (rnd() & 32'h1) brdy <= 1'b1;
        end
        r = br;
        brdy <= 1'b0;
    endtask
    task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        ara <= a;
        arv <= 1'b1;
        forever begin
            tick(n);
            if (arv && arr) arv <= 1'b0;
            if (rv && rrdy) break;
            if (rnd() & 32'h1) rrdy <= 1'b1;
        end
        d = rdata;
        r = rr;
        rrdy <= 1'b0;
    endtask
    task automatic chk_ctrl(input logic [7:0] c);
        rdreg(`LRC_ADDR_CTRL, rd, resp);
        `CHK("ctrl", {24'h0, c}, rd)
        `CHK("power", c[7], pwr)
        `CHK("route", c[6], route)
        `CHK("range", c[5], rng)
        `CHK("supply", c[4], sup)
        `CHK("code", c[3:0], code)
        `CHK("tap", exp_tap(c), tap)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        {awv, wv, brdy, arv, rrdy, pin, dir} = 7'h00;
        {awa, ara, wd, ws, mode} = '0;
        sys_rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("reset tap", 7'h18, tap)
        chk_ctrl(8'h00);
        // Corner bytes first, then random bytes; every mode visited
        for (int i = 0; i < 24; i++) begin
            v = (i < 6) ? corner[i] : 8'(rnd());
            mode <= i[2:0];
            {dir, pin} <= seed[9:8];
            wr(`LRC_ADDR_CTRL, {seed[31:8], v}, 4'hF, resp);
            `CHK("wr resp", `LRC_RESP_OKAY, resp)
            chk_ctrl(v);
            repeat (3) @(posedge clk_i);
            `CHK("pin oe", ~v[6] & ~dir, oe)
            `CHK("cmp", v[7] && mode == `LRC_MODE_REF, conn)
        end
        // Refused writes leave the control byte alone
        wr(`LRC_ADDR_CTRL, {24'h0, ~v}, 4'hE, resp);
        `CHK("nostrb resp", `LRC_RESP_OKAY, resp)
        wr(8'h08, {24'h0, ~v}, 4'hF, resp);
        `CHK("unmapped wr", `LRC_RESP_SLVERR, resp)
        rdreg(8'h08, rd, resp);
        `CHK("unmapped rd", `LRC_RESP_SLVERR, resp)
        `CHK("unmapped data", 32'h0, rd)
        mode <= `LRC_MODE_REF;
        wr(`LRC_ADDR_STAT, 32'hFF, 4'hF, resp);
        `CHK("status wr", `LRC_RESP_OKAY, resp)
        rdreg(`LRC_ADDR_STAT, rd, resp);
        `CHK("status tap", exp_tap(v), rd[6:0])
        `CHK("status cmp", v[7] && mode == `LRC_MODE_REF, rd[8])
        `CHK("status pin", pin, rd[9])
        chk_ctrl(v);
        // Power dropped ahead of a sleep, other bits kept
        wr(`LRC_ADDR_CTRL, {24'h0, v & 8'h7F}, 4'hF, resp);
        chk_ctrl(v & 8'h7F);
        // Reset in mid-run clears a fully set byte
        wr(`LRC_ADDR_CTRL, 32'hFF, 4'hF, resp);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk_ctrl(8'h00);
        end_of_test();
    end
endmodule // test_lrc_top
